// >>> rtl/s_curve_pkg.sv
// s_curve_pkg: constants, parameter layout and carrier types of the s-curve profiler
// assumes: one 20 MHz control clock, synchronous active-high reset
package s_curve_pkg;

   // ***********************************
   // clock and update interval
   // ***********************************
   localparam int unsigned CLK_PERIOD_NS  = 50;
   localparam int unsigned UPDATE_TIME_NS = 1000000;
   localparam int unsigned UPDATE_CYCLES  = UPDATE_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned DIV_W          = 32;

   // ***********************************
   // parameter sets
   // ***********************************
   localparam int unsigned NUM_SETS   = 4;
   localparam int unsigned NUM_VALUES = 6;
   localparam int unsigned PAR_W      = 16;

   // value index inside a set
   localparam logic [2:0] IDX_ACCEL_RATE     = 3'h0;
   localparam logic [2:0] IDX_DECEL_RATE     = 3'h1;
   localparam logic [2:0] IDX_ACCEL_JERK_IN  = 3'h2;
   localparam logic [2:0] IDX_ACCEL_JERK_OUT = 3'h3;
   localparam logic [2:0] IDX_DECEL_JERK_IN  = 3'h4;
   localparam logic [2:0] IDX_DECEL_JERK_OUT = 3'h5;

   // rates in 0.01 ft/s2, jerks in 0.1 ft/s3
   localparam logic [PAR_W-1:0] RATE_MAX     = 16'h031f;
   localparam logic [PAR_W-1:0] RATE_DEFAULT = 16'h012c;
   localparam logic [PAR_W-1:0] JERK_MAX     = 16'h012b;
   localparam logic [PAR_W-1:0] JERK_DEFAULT = 16'h0050;

   // rate raw unit to internal accel unit (1e-4 ft/s2)
   localparam logic [15:0] RATE_SCALE = 16'h0064;

   // profile set numbers
   localparam logic [1:0] PROFILE_SET_ZERO  = 2'h0;
   localparam logic [1:0] PROFILE_SET_ONE   = 2'h1;
   localparam logic [1:0] PROFILE_SET_TWO   = 2'h2;
   localparam logic [1:0] PROFILE_SET_THREE = 2'h3;

   // ***********************************
   // carrier types
   // ***********************************
   typedef logic [NUM_VALUES-1:0][PAR_W-1:0] param_set_t;
   typedef param_set_t [NUM_SETS-1:0]        param_bank_t;

   typedef struct packed {
      logic             valid;
      logic [1:0]       set;
      logic [2:0]       idx;
      logic [PAR_W-1:0] data;
   } param_wr_t;

   typedef struct packed {
      logic       sel0_assigned;
      logic       sel1_assigned;
      logic       sel0;
      logic       sel1;
   } profile_sel_t;

endpackage

// >>> rtl/s_curve_speed_profiler.sv
// s_curve_speed_profiler: speed reference generator with rate and jerk limits
// assumes: inputs synchronous to ref_clk_i; speed in units of 1e-7 ft/s,
// accel in 1e-4 ft/s2; one profile step per update interval
//
// Overview of operation
// RULE_01: speed reference follows the command, never beyond active rate or jerk limits.
// RULE_02: four parameter sets, each with two rates and four jerks.
// RULE_03: no select input assigned means set zero is always used.
// RULE_04: select bits (bit1, bit0) choose set 0, 1, 2 or 3 directly.
// RULE_05: an unassigned select bit reads as zero.
// RULE_06: a jerk value of zero removes that jerk limit.
// RULE_07: a rate value of zero removes that rate limit.
// RULE_08: accel rate accepted 0.00 to 7.99 ft/s2, default 3.00.
// RULE_09: decel rate accepted 0.00 to 7.99 ft/s2, default 3.00, used slowing down.
// RULE_10: accel rises toward accel rate no faster than accel onset jerk.
// RULE_11: accel falls to zero near target no faster than accel release jerk.
// RULE_12: decel rises toward decel rate no faster than decel onset jerk.
// RULE_13: decel falls to zero near target no faster than decel release jerk.
// RULE_14: controller shaping its own profile sets set zero to max rates, zero jerks.
// RULE_15: parameter writes refused while running, accepted otherwise; code also refuses an index above 5 or a value above its max.
// RULE_16: accel and speed updated once per fixed update interval, limits clamped.
// RULE_17: select sampled continuously; new set applies without touching speed.
`timescale 1ns/10ps
`default_nettype none

module s_curve_speed_profiler
#(
   parameter int unsigned UPDATE_CYCLES = s_curve_pkg::UPDATE_CYCLES
)
(
   input  wire logic                      ref_clk_i,
   input  wire logic                      rst_i,
   input  wire logic signed [31:0]        speed_cmd_i,
   input  wire s_curve_pkg::profile_sel_t profile_sel_i,
   input  wire logic                      running_i,
   input  wire s_curve_pkg::param_wr_t    param_wr_i,
   output logic signed [31:0]             speed_ref_o,
   output logic signed [31:0]             accel_o,
   output logic [1:0]                     active_set_o,
   output logic                           update_o,
   output logic                           wr_ack_o,
   output logic                           wr_reject_o
);

   // ***********************************
   // state
   // ***********************************
   typedef struct packed {
      s_curve_pkg::param_bank_t        bank;
      logic [s_curve_pkg::DIV_W-1:0]   div;
      logic                            tick;
      logic [1:0]                      active_set;
      logic signed [31:0]              speed;
      logic signed [31:0]              accel;
      logic                            wr_ack;
      logic                            wr_reject;
   } state_t;

   state_t r;
   state_t next_r;

   // ***********************************
   // next state
   // ***********************************
   always_comb
   begin
      logic [1:0]                  sel;
      logic [15:0]                 wr_max;
      s_curve_pkg::param_set_t     sp;
      logic                        neg;
      logic                        speeding;
      logic signed [79:0]          err;
      logic signed [79:0]          em;
      logic signed [79:0]          am;
      logic signed [79:0]          am_n;
      logic signed [79:0]          lim;
      logic signed [79:0]          jin;
      logic signed [79:0]          jout;
      logic                        release_now;
      sel         = 2'h0;
      wr_max      = 16'h0000;
      sp          = '0;
      neg         = 1'b0;
      speeding    = 1'b0;
      err         = '0;
      em          = '0;
      am          = '0;
      am_n        = '0;
      lim         = '0;
      jin         = '0;
      jout        = '0;
      release_now = 1'b0;
      next_r      = r;
      next_r.wr_ack    = 1'b0;
      next_r.wr_reject = 1'b0;
      next_r.tick      = 1'b0;

      // unassigned bits read zero, none assigned gives set zero
      sel[0] = profile_sel_i.sel0 & profile_sel_i.sel0_assigned;   // see RULE_03 see RULE_05
      sel[1] = profile_sel_i.sel1 & profile_sel_i.sel1_assigned;   // see RULE_05
      next_r.active_set = sel;   // see RULE_04 see RULE_17

      // parameter write, range checked, locked while running
      if (param_wr_i.idx == s_curve_pkg::IDX_ACCEL_RATE ||
          param_wr_i.idx == s_curve_pkg::IDX_DECEL_RATE)
      begin
         wr_max = s_curve_pkg::RATE_MAX;   // see RULE_08 see RULE_09
      end
      else
      begin
         wr_max = s_curve_pkg::JERK_MAX;
      end
      if (param_wr_i.valid)
      begin
         if (running_i ||
             param_wr_i.idx >= 3'(s_curve_pkg::NUM_VALUES) ||
             param_wr_i.data > wr_max)
         begin
            next_r.wr_reject = 1'b1;   // see RULE_15
         end
         else
         begin
            next_r.bank[param_wr_i.set][param_wr_i.idx] = param_wr_i.data;   // see RULE_02
            next_r.wr_ack = 1'b1;
         end
      end

      // update interval divider
      if (r.div >= s_curve_pkg::DIV_W'(UPDATE_CYCLES - 1))
      begin
         next_r.div  = '0;
         next_r.tick = 1'b1;   // see RULE_16
      end
      else
      begin
         next_r.div = r.div + 1'b1;
      end

      // profile step, all in magnitude toward the command
      sp  = r.bank[r.active_set];   // see RULE_17
      err = 80'(speed_cmd_i) - 80'(r.speed);
      neg = err[79];
      em  = neg ? -err : err;
      am  = neg ? -80'(r.accel) : 80'(r.accel);
      speeding = (r.speed == 32'sh0) || (!neg && !r.speed[31]) || (neg && r.speed[31]);
      if (speeding)
      begin
         lim  = 80'(sp[s_curve_pkg::IDX_ACCEL_RATE]) * 80'(s_curve_pkg::RATE_SCALE);   // see RULE_08
         jin  = 80'(sp[s_curve_pkg::IDX_ACCEL_JERK_IN]);    // see RULE_10
         jout = 80'(sp[s_curve_pkg::IDX_ACCEL_JERK_OUT]);   // see RULE_11
      end
      else
      begin
         lim  = 80'(sp[s_curve_pkg::IDX_DECEL_RATE]) * 80'(s_curve_pkg::RATE_SCALE);   // see RULE_09
         jin  = 80'(sp[s_curve_pkg::IDX_DECEL_JERK_IN]);    // see RULE_12
         jout = 80'(sp[s_curve_pkg::IDX_DECEL_JERK_OUT]);   // see RULE_13
      end

      // start releasing once the ramp-out distance reaches the remaining error
      if (am > 80'sd0)
      begin
         if (jout == 80'sd0)
         begin
            release_now = (am >= em);   // see RULE_06
         end
         else
         begin
            release_now = (am * am >= 80'sd2 * jout * em);   // see RULE_11 see RULE_13
         end
      end

      if (em == 80'sd0)
      begin
         am_n = 80'sd0;
      end
      else if (release_now)
      begin
         if (jout == 80'sd0)
         begin
            am_n = em;   // see RULE_06
         end
         else
         begin
            am_n = am - jout;   // see RULE_11 see RULE_13
            if (am_n < 80'sd1)
            begin
               am_n = 80'sd1;
            end
         end
      end
      else
      begin
         if (jin == 80'sd0)
         begin
            am_n = (lim == 80'sd0) ? em : lim;   // see RULE_06 see RULE_07
         end
         else
         begin
            am_n = am + jin;   // see RULE_10 see RULE_12
         end
         if (lim != 80'sd0 && am_n > lim)
         begin
            am_n = lim;   // see RULE_01 see RULE_07
         end
      end
      if (am_n > em)
      begin
         am_n = em;   // see RULE_01
      end

      if (r.tick)
      begin
         next_r.accel = neg ? -32'(am_n) : 32'(am_n);          // see RULE_16
         next_r.speed = r.speed + (neg ? -32'(am_n) : 32'(am_n));   // see RULE_01
      end

      if (rst_i)
      begin
         next_r.div        = '0;
         next_r.tick       = 1'b0;
         next_r.active_set = s_curve_pkg::PROFILE_SET_ZERO;
         next_r.speed      = 32'sh0;
         next_r.accel      = 32'sh0;
         next_r.wr_ack     = 1'b0;
         next_r.wr_reject  = 1'b0;
         for (int s = 0; s < s_curve_pkg::NUM_SETS; s++)
         begin
            next_r.bank[s][s_curve_pkg::IDX_ACCEL_RATE]     = s_curve_pkg::RATE_DEFAULT;
            next_r.bank[s][s_curve_pkg::IDX_DECEL_RATE]     = s_curve_pkg::RATE_DEFAULT;
            next_r.bank[s][s_curve_pkg::IDX_ACCEL_JERK_IN]  = s_curve_pkg::JERK_DEFAULT;
            next_r.bank[s][s_curve_pkg::IDX_ACCEL_JERK_OUT] = s_curve_pkg::JERK_DEFAULT;
            next_r.bank[s][s_curve_pkg::IDX_DECEL_JERK_IN]  = s_curve_pkg::JERK_DEFAULT;
            next_r.bank[s][s_curve_pkg::IDX_DECEL_JERK_OUT] = s_curve_pkg::JERK_DEFAULT;
         end
      end
   end

   // ***********************************
   // registers and outputs
   // ***********************************
   always_ff @(posedge ref_clk_i)
   begin
      r <= next_r;
   end

   assign speed_ref_o  = r.speed;
   assign accel_o      = r.accel;
   assign active_set_o = r.active_set;
   assign update_o     = r.tick;
   assign wr_ack_o     = r.wr_ack;
   assign wr_reject_o  = r.wr_reject;

endmodule

`default_nettype wire

// >>> dv/s_curve_checker.sv
// s_curve_checker: port assertions for the s-curve profiler
// assumes: bound to the top module, one clock, reset high
`timescale 1ns/10ps
`default_nettype none
module s_curve_checker
#(
   parameter int UPDATE_CYCLES = 8
)
(
   input wire logic                      ref_clk_i,
   input wire logic                      rst_i,
   input wire logic signed [31:0]        speed_cmd_i,
   input wire s_curve_pkg::profile_sel_t profile_sel_i,
   input wire logic                      running_i,
   input wire s_curve_pkg::param_wr_t    param_wr_i,
   input wire logic signed [31:0]        speed_ref_o,
   input wire logic signed [31:0]        accel_o,
   input wire logic [1:0]                active_set_o,
   input wire logic                      update_o,
   input wire logic                      wr_ack_o,
   input wire logic                      wr_reject_o
);
   // ***********************
   // assertions
   // ***********************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // cycles since the last update, reset aligned with the divider
   int gap;
   always_ff @(posedge ref_clk_i)
   begin
      if (rst_i)
         gap <= -1;
      else if (update_o)
         gap <= 0;
      else
         gap <= gap + 1;
   end
   property p_answer; param_wr_i.valid |=> wr_ack_o != wr_reject_o; endproperty
   a_answer: assert property (p_answer) else $error("write not answered");
   property p_quiet; !param_wr_i.valid |=> !wr_ack_o && !wr_reject_o; endproperty
   a_quiet: assert property (p_quiet) else $error("answer without write");
   property p_locked; param_wr_i.valid && running_i |=> wr_reject_o; endproperty
   a_locked: assert property (p_locked) else $error("write taken while running");
   property p_range; param_wr_i.valid && param_wr_i.idx > 3'h5 |=> wr_reject_o; endproperty
   a_range: assert property (p_range) else $error("bad index taken");
   property p_sel;
      1'b1 |=> active_set_o == $past({profile_sel_i.sel1 & profile_sel_i.sel1_assigned,
                                      profile_sel_i.sel0 & profile_sel_i.sel0_assigned});
   endproperty
   a_sel: assert property (p_sel) else $error("wrong active set");
   property p_hold; !$past(update_o) |-> $stable(speed_ref_o) && $stable(accel_o); endproperty
   a_hold: assert property (p_hold) else $error("output moved off update");
   property p_pair; $past(update_o) |-> speed_ref_o == $past(speed_ref_o) + accel_o; endproperty
   a_pair: assert property (p_pair) else $error("step not added");
   property p_no_pass;
      $past(update_o) && $past(speed_cmd_i) >= $past(speed_ref_o)
         |-> speed_ref_o <= $past(speed_cmd_i) && speed_ref_o >= $past(speed_ref_o);
   endproperty
   a_no_pass: assert property (p_no_pass) else $error("reference passed command");
   property p_period; update_o |-> gap == UPDATE_CYCLES - 1; endproperty
   a_period: assert property (p_period) else $error("update interval wrong");
   property p_gap; gap < UPDATE_CYCLES; endproperty
   a_gap: assert property (p_gap) else $error("update missing");
endmodule
bind s_curve_speed_profiler s_curve_checker #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .speed_cmd_i(speed_cmd_i),
   .profile_sel_i(profile_sel_i), .running_i(running_i), .param_wr_i(param_wr_i),
   .speed_ref_o(speed_ref_o), .accel_o(accel_o), .active_set_o(active_set_o),
   .update_o(update_o), .wr_ack_o(wr_ack_o), .wr_reject_o(wr_reject_o));
`default_nettype wire

// >>> dv/car_ctrl_model.sv
// car_ctrl_model: car controller giving target speed commands
// assumes: step chosen by the bench, command changes on falling edge
`timescale 1ns/10ps
`default_nettype none
module car_ctrl_model
(
   input  wire logic          ref_clk_i,
   input  wire logic [1:0]    step_i,
   output logic signed [31:0] speed_cmd_o
);
   // ***********************
   // command table
   // ***********************
   always @(negedge ref_clk_i)
   begin
      case (step_i)
         2'h1:    speed_cmd_o <= 32'h0010_0000;
         2'h2:    speed_cmd_o <= 32'h0000_1000;
         2'h3:    speed_cmd_o <= 32'hfff0_0000;
         default: speed_cmd_o <= 32'h0;
      endcase
   end
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: self-checking bench for the s-curve profiler
// assumes: update interval shortened to 8 cycles
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ***********************
   // bench
   // ***********************
   localparam int UPD = 8;
   logic                      ref_clk_i = 1'b0;
   logic                      rst_i     = 1'b1;
   logic                      running_i = 1'b0;
   logic [1:0]                step      = 2'h0;
   s_curve_pkg::profile_sel_t sel       = '0;
   s_curve_pkg::param_wr_t    wr        = '0;
   logic signed [31:0]        cmd, sref, acc;
   logic [1:0]                aset;
   logic                      upd, ack, rej;
   int                        err_total = 0;
   int                        num_checks = 0;
   int                        cyc = 0;
   // select in, expected set
   logic [5:0] rows [8] = '{6'h00, 6'h08, 6'h0c, 6'h29, 6'h16, 6'h3f, 6'h24, 6'h39};
   // step sizes of a default-set ramp toward 0x1000
   logic [31:0] mags [8] = '{32'h50, 32'ha0, 32'hf0, 32'h140, 32'h190, 32'h1e0, 32'h230,
                             32'h1e0};
   car_ctrl_model u_car (.ref_clk_i(ref_clk_i), .step_i(step), .speed_cmd_o(cmd));
   s_curve_speed_profiler #(.UPDATE_CYCLES(UPD)) dut (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .speed_cmd_i(cmd), .profile_sel_i(sel),
      .running_i(running_i), .param_wr_i(wr), .speed_ref_o(sref), .accel_o(acc),
      .active_set_o(aset), .update_o(upd), .wr_ack_o(ack), .wr_reject_o(rej));
   always #25 ref_clk_i = ~ref_clk_i;
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (cyc == 2000)
      begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr_par(input logic [1:0] s, input logic [2:0] i, input logic [15:0] d,
                         input logic ok);
      @(negedge ref_clk_i);
      wr = '{1'b1, s, i, d};
      @(negedge ref_clk_i);
      wr.valid = 1'b0;
      chk({ack, rej}, {ok, ~ok});
   endtask
   task automatic wait_upd;
      int n;
      for (n = 0; n < 20 && upd !== 1'b1; n++) @(negedge ref_clk_i);
      chk({31'h0, upd}, 32'h1);
      @(negedge ref_clk_i);
   endtask
   initial
   begin
      repeat (12) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk(sref, 32'h0);
      chk(aset, 2'h0);
      $display("test reset done");
      for (int r = 0; r < 8; r++)
      begin
         @(negedge ref_clk_i);
         sel = rows[r][5:2];
         @(negedge ref_clk_i);
         chk(aset, rows[r][1:0]);
      end
      sel = '0;
      $display("test select done");
      running_i = 1'b1;
      wr_par(2'h1, 3'h2, 16'h0000, 1'b0);
      running_i = 1'b0;
      wr_par(2'h1, 3'h6, 16'h0000, 1'b0);
      wr_par(2'h1, 3'h0, 16'h0320, 1'b0);
      wr_par(2'h1, 3'h1, 16'h0320, 1'b0);
      wr_par(2'h1, 3'h2, 16'h012c, 1'b0);
      for (int i = 0; i < 6; i++) wr_par(2'h1, i[2:0], 16'h0000, 1'b1);
      $display("test writes done");
      step <= 2'h1;
      wait_upd();
      chk(acc, 32'h50);
      wait_upd();
      chk(acc, 32'ha0);
      chk(sref, 32'hf0);
      sel = 4'ha;
      @(negedge ref_clk_i);
      chk(sref, 32'hf0);
      wait_upd();
      chk(sref, 32'h0010_0000);
      $display("test profile done");
      step <= 2'h0;
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      chk(sref, 32'h0);
      wr_par(2'h2, 3'h0, 16'h031f, 1'b1);
      wr_par(2'h2, 3'h2, 16'h012b, 1'b1);
      sel = 4'h5;
      step <= 2'h1;
      wait_upd();
      chk(acc, 32'h12b);
      $display("test second reset done");
      step <= 2'h0;
      sel = 4'hf;
      rst_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 6; i++)
      begin
         wr_par(2'h0, i[2:0], (i < 2) ? 16'h031f : 16'h0000, 1'b1);
      end
      step <= 2'h2;
      for (int k = 0; k < 8; k++)
      begin
         wait_upd();
         chk(acc, mags[k]);
      end
      sel = '0;
      wait_upd();
      chk(sref, 32'h0000_1000);
      wait_upd();
      chk(acc, 32'h0);
      sel = 4'hf;
      step <= 2'h0;
      for (int k = 0; k < 8; k++)
      begin
         wait_upd();
         chk(acc, -mags[k]);
      end
      chk(sref, 32'h560);
      $display("test ramps done");
      finish_test();
   end
endmodule
`default_nettype wire
